// ---- drive_status_checker.sv ----
// assertions on the ports of the drive status block
// assumes pclk and active-low async presetn; bound at the foot
`timescale 1ns/1ps
`include "drive_status_regs.vh"
module drive_status_checker #(
    parameter TICK_CYCLES = 200000
) (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // monitored values
    input wire [15:0] pid_setpoint,
    input wire [15:0] pid_process_value,
    input wire [15:0] torque_estimate,
    input wire        motor_reverse,
    input wire        fault_alarm,
    // outputs
    input wire [4:0]  oc_out,
    input wire [4:0]  oc_oe,
    input wire        relay_coil,
    input wire        relay_pole_b,
    input wire        relay_pole_c,
    input wire        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // shadows of software settings so outputs can be tied to writes
    int        up_cnt;
    reg [15:0] dev_sh;
    reg [2:0]  mask_sh;
    wire       wr_acc = psel && penable && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt  <= 0;
            dev_sh  <= `DEV_LEVEL_RESET;
            mask_sh <= 3'h0;
        end else begin
            if (up_cnt < 1000) up_cnt <= up_cnt + 1;
            if (wr_acc && paddr == `OFS_DEV_LEVEL) dev_sh <= pwdata[15:0];
            if (wr_acc && paddr == `OFS_INT_MASK) mask_sh <= pwdata[2:0];
        end
    end
    // ==========================================================
    // apb and output properties
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd_dev; s_setup ##0 (!pwrite && paddr == `OFS_DEV_LEVEL); endsequence
    property p_ready; pready; endproperty
    property p_err; s_setup |=> pslverr == ($past(paddr) > `OFS_INT_MASK); endproperty
    property p_wr_zero; s_setup ##0 pwrite |=> prdata == 32'h0; endproperty
    property p_dev_back; s_rd_dev |=> prdata == {16'h0, dev_sh}; endproperty
    property p_oc_low; oc_out == 5'h00; endproperty
    property p_poles; relay_pole_b == relay_coil && relay_pole_c == !relay_coil; endproperty
    property p_start_low; up_cnt < TICK_CYCLES |-> !relay_coil; endproperty
    property p_start_close; up_cnt == 4 * TICK_CYCLES |-> relay_coil; endproperty
    property p_flt_hold; $rose(fault_alarm) |=> $stable(relay_coil) [*8]; endproperty
    property p_irq_mask; mask_sh == 3'h0 |-> !irq; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_err: assert property (p_err) else $error("pslverr does not match address");
    a_wr_zero: assert property (p_wr_zero) else $error("prdata nonzero on write");
    a_dev_back: assert property (p_dev_back) else $error("deviation threshold readback wrong");
    a_oc_low: assert property (p_oc_low) else $error("open collector driven high");
    a_poles: assert property (p_poles) else $error("relay poles disagree with coil");
    a_start_low: assert property (p_start_low) else $error("coil on too early");
    a_start_close: assert property (p_start_close) else $error("contact not closed after power-up");
    a_flt_hold: assert property (p_flt_hold) else $error("relay moved before fault delay");
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
endmodule
bind drive_status_outputs drive_status_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pid_setpoint(pid_setpoint), .pid_process_value(pid_process_value),
    .torque_estimate(torque_estimate), .motor_reverse(motor_reverse), .fault_alarm(fault_alarm),
    .oc_out(oc_out), .oc_oe(oc_oe), .relay_coil(relay_coil), .relay_pole_b(relay_pole_b),
    .relay_pole_c(relay_pole_c), .irq(irq));

// ---- drive_status_outputs.v ----
// status output logic of a motor drive: pid deviation, fault and torque-excess flags
// routed to five open-collector outputs and a changeover relay, set up over apb
// assumes pid, torque and fault inputs come from logic on pclk; outputs go to pin drivers
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "drive_status_regs.vh"
module drive_status_outputs #(
    parameter TICK_CYCLES   = `CYCLES_PER_MS,
    parameter FAULT_DELAY   = `FAULT_DELAY_MS,
    parameter STARTUP_DELAY = `STARTUP_MS
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // pid loop values, 0.1 percent units
    input  wire [15:0] pid_setpoint,
    input  wire [15:0] pid_process_value,
    // torque estimate, signed percent, and motor direction
    input  wire [15:0] torque_estimate,
    input  wire        motor_reverse,
    // trip logic
    input  wire        fault_alarm,
    // open-collector outputs
    output reg  [4:0]  oc_out,
    output reg  [4:0]  oc_oe,
    // relay
    output reg         relay_coil,
    output reg         relay_pole_b,
    output reg         relay_pole_c,
    // interrupt
    output wire        irq
);

    // ==========================================================
    // functions
    // pick one flag by its function code; unknown codes read as off
    function sel_flag;
        input [7:0] code;
        input       dev;
        input       flt;
        input       trq;
        begin
            case (code)
                `FN_DEVIATION: sel_flag = dev;
                `FN_FAULT:     sel_flag = flt;
                `FN_TORQUE:    sel_flag = trq;
                default:       sel_flag = 1'b0;
            endcase
        end
    endfunction

    // torque levels above the documented ceiling are stored as the ceiling
    function [7:0] clamp_level;
        input [7:0] v;
        begin
            clamp_level = (v > `TORQUE_MAX) ? `TORQUE_MAX : v;
        end
    endfunction

    // ==========================================================
    // registers
    reg  [1:0]  relay_polarity_select;
    reg  [3:0]  motor_control_method;
    reg  [31:0] oc_sel;
    reg  [7:0]  output_five_function_select;
    reg  [7:0]  relay_function_select;
    reg  [15:0] deviation_threshold;
    reg  [7:0]  fwd_drive_torque_level;
    reg  [7:0]  rev_regen_torque_level;
    reg  [7:0]  rev_drive_torque_level;
    reg  [7:0]  fwd_regen_torque_level;
    reg  [2:0]  int_status;
    reg  [2:0]  int_mask;

    wire        wr_en;
    wire        rd_setup;
    wire        pid_deviation_flag;
    wire        torque_excess_flag;
    reg         fault_flag;
    reg  [2:0]  flags_d;
    wire [2:0]  flags_now;
    wire [2:0]  flag_rise;
    reg  [31:0] next_prdata;
    reg         next_pslverr;

    assign pready   = 1'b1; // zero wait states
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;

    // ==========================================================
    // pid deviation
    wire [15:0] pid_error;
    assign pid_error = (pid_setpoint >= pid_process_value) ?
                       (pid_setpoint - pid_process_value) :
                       (pid_process_value - pid_setpoint);

    flag_compare #(
        .WIDTH     (16)
    ) u_dev_cmp (
        .pclk      (pclk),
        .presetn   (presetn),
        .value     (pid_error),
        .threshold (deviation_threshold),
        .enable    (1'b1),
        .flag      (pid_deviation_flag)
    );

    // ==========================================================
    // torque excess, monitoring only: nothing here feeds back to the torque path
    wire        torque_neg;
    wire [15:0] torque_mag;
    reg  [7:0]  quad_level;
    wire        method_ok;
    assign torque_neg = torque_estimate[15];
    assign torque_mag = torque_neg ? (16'h0000 - torque_estimate) : torque_estimate;
    assign method_ok  = (motor_control_method == `METHOD_SLV) ||
                        (motor_control_method == `METHOD_ZERO_HZ) ||
                        (motor_control_method == `METHOD_SENSOR);

    // quadrant from rotation and torque sign
    always @* begin
        case ({motor_reverse, torque_neg})
            2'b00:   quad_level = fwd_drive_torque_level;
            2'b01:   quad_level = fwd_regen_torque_level;
            2'b11:   quad_level = rev_drive_torque_level;
            2'b10:   quad_level = rev_regen_torque_level;
            default: quad_level = fwd_drive_torque_level;
        endcase
    end

    flag_compare #(
        .WIDTH     (16)
    ) u_trq_cmp (
        .pclk      (pclk),
        .presetn   (presetn),
        .value     (torque_mag),
        .threshold ({8'h00, quad_level}),
        .enable    (method_ok),
        .flag      (torque_excess_flag)
    );

    // ==========================================================
    // millisecond tick divider
    reg [17:0] tick_cnt;
    wire       ms_tick;
    assign ms_tick = (tick_cnt == TICK_CYCLES[17:0] - 18'h00001);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 18'h00000;
        end else if (ms_tick) begin
            tick_cnt <= 18'h00000;
        end else begin
            tick_cnt <= tick_cnt + 18'h00001;
        end
    end

    // ==========================================================
    // fault flag delay: alarm must stand FAULT_DELAY free-running ms ticks, so more than FAULT_DELAY-1 ms; drops at once on clear
    reg [`MS_COUNT_W-1:0] fault_ms;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_ms   <= {`MS_COUNT_W{1'b0}};
            fault_flag <= 1'b0;
        end else if (!fault_alarm) begin
            fault_ms   <= {`MS_COUNT_W{1'b0}};
            fault_flag <= 1'b0;
        end else if (fault_ms == FAULT_DELAY[`MS_COUNT_W-1:0]) begin
            fault_flag <= 1'b1;
        end else if (ms_tick) begin
            fault_ms <= fault_ms + 1'b1;
        end
    end

    // ==========================================================
    // power-up hold: coil stays dead until the startup time passes
    reg [`MS_COUNT_W-1:0] start_ms;
    reg                   started;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ms <= {`MS_COUNT_W{1'b0}};
            started  <= 1'b0;
        end else if (start_ms == STARTUP_DELAY[`MS_COUNT_W-1:0]) begin
            started <= 1'b1;
        end else if (ms_tick) begin
            start_ms <= start_ms + 1'b1;
        end
    end

    // ==========================================================
    // output routing
    // a dead coil leaves b open and c closed, matching the unpowered contact state
    wire relay_fn;
    wire coil_on;
    assign relay_fn = sel_flag(relay_function_select, pid_deviation_flag, fault_flag,
                               torque_excess_flag);
    assign coil_on  = started & ((relay_polarity_select == `POL_INVERTED) ?
                                 relay_fn : ~relay_fn);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_out       <= 5'h00;
            oc_oe        <= 5'h00;
            relay_coil   <= 1'b0;
            relay_pole_b <= 1'b0;
            relay_pole_c <= 1'b1;
        end else begin
            oc_out       <= 5'h00; // only ever pulls low
            oc_oe[0]     <= sel_flag(oc_sel[7:0], pid_deviation_flag, fault_flag,
                                     torque_excess_flag);
            oc_oe[1]     <= sel_flag(oc_sel[15:8], pid_deviation_flag, fault_flag,
                                     torque_excess_flag);
            oc_oe[2]     <= sel_flag(oc_sel[23:16], pid_deviation_flag, fault_flag,
                                     torque_excess_flag);
            oc_oe[3]     <= sel_flag(oc_sel[31:24], pid_deviation_flag, fault_flag,
                                     torque_excess_flag);
            oc_oe[4]     <= sel_flag(output_five_function_select, pid_deviation_flag,
                                     fault_flag, torque_excess_flag);
            relay_coil   <= coil_on;
            relay_pole_b <= coil_on;
            relay_pole_c <= ~coil_on;
        end
    end

    // ==========================================================
    // interrupt events: each flag rising sets a sticky bit
    assign flags_now = {torque_excess_flag, fault_flag, pid_deviation_flag};
    assign flag_rise = flags_now & ~flags_d;
    assign irq       = |(int_status & int_mask);

    // ==========================================================
    // register writes; a new event wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_polarity_select       <= `POL_RESET;
            motor_control_method        <= `METHOD_RESET;
            oc_sel                      <= `OC_SEL_RESET;
            output_five_function_select <= 8'h00;
            relay_function_select       <= `RELAY_SEL_RESET;
            deviation_threshold         <= `DEV_LEVEL_RESET;
            fwd_drive_torque_level      <= 8'h64;
            rev_regen_torque_level      <= 8'h64;
            rev_drive_torque_level      <= 8'h64;
            fwd_regen_torque_level      <= 8'h64;
            int_status                  <= 3'h0;
            int_mask                    <= 3'h0;
            flags_d                     <= 3'h0;
        end else begin
            flags_d <= flags_now;
            if (wr_en && paddr == `OFS_INT_STATUS) begin
                int_status <= (int_status & ~pwdata[2:0]) | flag_rise;
            end else begin
                int_status <= int_status | flag_rise;
            end
            if (wr_en) begin
                case (paddr)
                    `OFS_CTRL: begin
                        relay_polarity_select <= pwdata[`POL_LSB+1:`POL_LSB];
                        motor_control_method  <= pwdata[`METHOD_LSB+3:`METHOD_LSB];
                    end
                    `OFS_OC_SEL: begin
                        oc_sel <= pwdata;
                    end
                    `OFS_AUX_SEL: begin
                        output_five_function_select <= pwdata[7:0];
                        relay_function_select       <= pwdata[`RELAY_SEL_LSB+7:`RELAY_SEL_LSB];
                    end
                    `OFS_DEV_LEVEL: begin
                        deviation_threshold <= pwdata[15:0];
                    end
                    `OFS_TORQUE_LEVEL: begin
                        fwd_drive_torque_level <= clamp_level(pwdata[7:0]);
                        rev_regen_torque_level <= clamp_level(pwdata[15:8]);
                        rev_drive_torque_level <= clamp_level(pwdata[23:16]);
                        fwd_regen_torque_level <= clamp_level(pwdata[31:24]);
                    end
                    `OFS_INT_MASK: begin
                        int_mask <= pwdata[2:0];
                    end
                    default: begin
                        int_mask <= int_mask;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // read mux, captured in the setup cycle so data stands through the access phase
    always @* begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `OFS_CTRL:         next_prdata = {20'h00000, motor_control_method, 6'h00,
                                              relay_polarity_select};
            `OFS_OC_SEL:       next_prdata = oc_sel;
            `OFS_AUX_SEL:      next_prdata = {16'h0000, relay_function_select,
                                              output_five_function_select};
            `OFS_DEV_LEVEL:    next_prdata = {16'h0000, deviation_threshold};
            `OFS_TORQUE_LEVEL: next_prdata = {fwd_regen_torque_level, rev_drive_torque_level,
                                              rev_regen_torque_level, fwd_drive_torque_level};
            `OFS_FLAGS:        next_prdata = {23'h000000, relay_coil, 5'h00, flags_now};
            `OFS_INT_STATUS:   next_prdata = {29'h00000000, int_status};
            `OFS_INT_MASK:     next_prdata = {29'h00000000, int_mask};
            default:           next_pslverr = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ---- drive_status_regs.vh ----
// register map, field positions, reset values and timing counts of the drive status outputs
// assumes a 200 MHz pclk and a 32-bit apb master with word-aligned accesses
//
// Summary of operation
// - pid error is the magnitude of setpoint minus process variable
// - code 04 output on while pid error exceeds threshold, off while below
// - deviation threshold resets to 3 percent and stays writable by software
// - any open-collector output or the relay carries code 04, 05 or 07
// - fault flag on from trip entry until fault cleared, off otherwise
// - fault flag output follows the internal alarm after a nominal 300 ms
// - normally closed relay contact closes within 2 s of power-up
// - default polarity: b closed, c open in normal; swapped in trip or power off
// - polarity 00: b open, c closed normal; reversed in trip; power off b open
// - four quadrant torque thresholds, each settable from 0 to 200 percent
// - torque flag on while torque exceeds present quadrant threshold, off below
// - torque flag valid only with control method 03, 04 or 05
// - torque monitoring only reports; it never limits or alters torque
// - each open-collector output picks its function by a select code, 07 torque
// - open-collector outputs are active low: transistor conducts while flag on
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH

// ==========================================================
// register byte offsets
`define OFS_CTRL          12'h000
`define OFS_OC_SEL        12'h004
`define OFS_AUX_SEL       12'h008
`define OFS_DEV_LEVEL     12'h00c
`define OFS_TORQUE_LEVEL  12'h010
`define OFS_FLAGS         12'h014
`define OFS_INT_STATUS    12'h018
`define OFS_INT_MASK      12'h01c

// ==========================================================
// field positions and reset values
`define POL_LSB           0
`define METHOD_LSB        8
`define POL_RESET         2'h1
`define POL_INVERTED      2'h0
`define METHOD_RESET      4'h0
`define OC_SEL_RESET      32'h00000000
`define RELAY_SEL_LSB     8
`define RELAY_SEL_RESET   8'h05
`define DEV_LEVEL_RESET   16'h001e
`define TORQUE_MAX        8'hc8
`define TORQUE_RESET      32'h64646464

// ==========================================================
// function and control method codes
`define FN_DEVIATION      8'h04
`define FN_FAULT          8'h05
`define FN_TORQUE         8'h07
`define METHOD_SLV        4'h3
`define METHOD_ZERO_HZ    4'h4
`define METHOD_SENSOR     4'h5

// ==========================================================
// timing
`define CLK_MHZ           200
`define CYCLES_PER_MS     (`CLK_MHZ * 1000)
`define FAULT_DELAY_MS    300
`define STARTUP_MS        100
`define MS_COUNT_W        9

`endif

// ---- flag_compare.v ----
// threshold comparator with a held flag for one monitored magnitude
// assumes value and threshold arrive unsigned on pclk from on-chip logic
`timescale 1ns/1ps
module flag_compare #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // compare operands
    input  wire [WIDTH-1:0] value,
    input  wire [WIDTH-1:0] threshold,
    input  wire             enable,
    // result
    output reg              flag
);

    // ==========================================================
    // compare
    // equality keeps the last state so a value sitting on the level does not chatter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else if (!enable) begin
            flag <= 1'b0;
        end else if (value > threshold) begin
            flag <= 1'b1;
        end else if (value < threshold) begin
            flag <= 1'b0;
        end
    end

endmodule

// ---- load_model.sv ----
// load model at the far side: pulled-up open-collector lines and relay contacts
// assumes the block drives oc_oe high while a transistor conducts
`timescale 1ns/1ps
module load_model (
    // open-collector drive
    input  wire [4:0] oc_out,
    input  wire [4:0] oc_oe,
    // relay contacts
    input  wire       relay_pole_b,
    input  wire       relay_pole_c,
    // what the loads see
    output wire [4:0] pin_level,
    output wire       lamp_b,
    output wire       lamp_c
);
    // a released line floats up to the pull-up, never keeps its last value
    assign pin_level = (oc_oe & oc_out) | ~oc_oe;
    // lamps wired through common-to-b and common-to-c
    assign lamp_b = relay_pole_b;
    assign lamp_c = relay_pole_c;
endmodule

// ---- tb_top.sv ----
// self-checking bench for the drive status block over apb
// assumes the checker binds itself; long counts shortened by parameters
`timescale 1ns/1ps
`include "drive_status_regs.vh"
module tb_top;
    // ==========================================================
    // signals
    reg         pclk, presetn, psel, penable, pwrite, motor_reverse, fault_alarm, rerr;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rdat;
    reg  [15:0] pid_setpoint, pid_process_value, torque_estimate;
    wire        pready, pslverr, relay_coil, relay_pole_b, relay_pole_c, irq, lamp_b, lamp_c;
    wire [31:0] prdata;
    wire [4:0]  oc_out, oc_oe, pin_level;
    integer     bad_count, checked, m;
    always #2.5 pclk = ~pclk;
    // short ms tick of 4 cycles keeps fault and startup delays to at most 12 and 8 cycles
    drive_status_outputs #(.TICK_CYCLES(4), .FAULT_DELAY(3), .STARTUP_DELAY(2)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pid_setpoint(pid_setpoint), .pid_process_value(pid_process_value),
        .torque_estimate(torque_estimate), .motor_reverse(motor_reverse), .fault_alarm(fault_alarm),
        .oc_out(oc_out), .oc_oe(oc_oe), .relay_coil(relay_coil), .relay_pole_b(relay_pole_b),
        .relay_pole_c(relay_pole_c), .irq(irq));
    load_model load_u (.oc_out(oc_out), .oc_oe(oc_oe), .relay_pole_b(relay_pole_b),
        .relay_pole_c(relay_pole_c), .pin_level(pin_level), .lamp_b(lamp_b), .lamp_c(lamp_c));
    // ==========================================================
    // tasks
    task complete_run;
        begin
            $display("mismatches %0d comparisons %0d", bad_count, checked);
            if (bad_count == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // one apb transfer; request held until pready is seen high, only the watchdog ends a stuck wait
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e, input string nm);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, e, rdat);
        end
    endtask
    // settle lets the output registers land past the edge before sampling
    task settle(input integer n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask
    task pid(input [15:0] sp, input [15:0] pv, input [4:0] e);
        begin
            @(posedge pclk);
            pid_setpoint <= sp;
            pid_process_value <= pv;
            settle(3);
            chk("pins", {27'h0, e}, {27'h0, pin_level});
        end
    endtask
    task trq(input r, input [15:0] t, input e);
        begin
            @(posedge pclk);
            motor_reverse <= r;
            torque_estimate <= t;
            settle(3);
            chk("torque pin", {31'h0, ~e}, {31'h0, pin_level[2]});
        end
    endtask
    task relay(input [1:0] e);
        chk("relay", {30'h0, e}, {30'h0, lamp_b, lamp_c});
    endtask
    task flt(input v);
        begin
            @(posedge pclk);
            fault_alarm <= v;
        end
    endtask
    // ==========================================================
    // watchdog sized well beyond the roughly 1200 ns the tests need
    initial begin
        #50000;
        bad_count = bad_count + 1;
        $display("watchdog expired");
        complete_run;
    end
    // ==========================================================
    // main sequence
    initial begin
        bad_count = 0;
        checked = 0;
        {pclk, presetn, psel, penable, pwrite, motor_reverse, fault_alarm} = 7'h0;
        {paddr, pwdata, pid_setpoint, pid_process_value, torque_estimate} = 92'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_CTRL, 32'h00000001, "ctrl");
        rd(`OFS_OC_SEL, 32'h00000000, "oc_sel");
        rd(`OFS_AUX_SEL, 32'h00000500, "aux_sel");
        rd(`OFS_DEV_LEVEL, 32'h0000001e, "dev_level");
        rd(`OFS_TORQUE_LEVEL, 32'h64646464, "torque_level");
        rd(`OFS_INT_STATUS, 32'h0, "int_status");
        rd(`OFS_INT_MASK, 32'h0, "int_mask");
        rd(12'h020, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, rerr});
        settle(10);
        relay(2'b10);
        apb(1'b1, `OFS_DEV_LEVEL, 32'h00000028);
        rd(`OFS_DEV_LEVEL, 32'h00000028, "dev_level");
        apb(1'b1, `OFS_OC_SEL, 32'h00070504);
        apb(1'b1, `OFS_AUX_SEL, 32'h00000504);
        apb(1'b1, `OFS_INT_MASK, 32'h00000001);
        pid(16'd100, 16'd50, 5'b01110);
        chk("irq", 32'h1, {31'h0, irq});
        pid(16'd100, 16'd60, 5'b01110);
        pid(16'd100, 16'd61, 5'b11111);
        pid(16'd60, 16'd100, 5'b11111);
        pid(16'd50, 16'd100, 5'b01110);
        rd(`OFS_INT_STATUS, 32'h1, "int_status");
        apb(1'b1, `OFS_INT_STATUS, 32'h00000001);
        rd(`OFS_INT_STATUS, 32'h0, "int_status");
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, `OFS_FLAGS, 32'h0);
        rd(`OFS_FLAGS, 32'h00000101, "flags");
        apb(1'b1, `OFS_TORQUE_LEVEL, 32'hff00c9c8);
        rd(`OFS_TORQUE_LEVEL, 32'hc800c8c8, "torque_level");
        apb(1'b1, `OFS_TORQUE_LEVEL, 32'h281e140a);
        trq(1'b0, 16'd11, 1'b0);
        for (m = 2; m < 7; m = m + 1) begin
            apb(1'b1, `OFS_CTRL, {20'h0, m[3:0], 8'h01});
            trq(1'b0, 16'd11, m >= 3 && m <= 5);
        end
        apb(1'b1, `OFS_CTRL, 32'h00000501);
        trq(1'b0, 16'd11, 1'b1);
        trq(1'b0, -16'sd39, 1'b0);
        trq(1'b0, -16'sd41, 1'b1);
        trq(1'b1, 16'd21, 1'b1);
        trq(1'b1, 16'd19, 1'b0);
        trq(1'b1, -16'sd31, 1'b1);
        trq(1'b1, -16'sd29, 1'b0);
        flt(1'b1);
        settle(10);
        relay(2'b10);
        settle(12);
        relay(2'b01);
        chk("fault pin", 32'h0, {31'h0, pin_level[1]});
        flt(1'b0);
        settle(3);
        relay(2'b10);
        chk("fault pin", 32'h1, {31'h0, pin_level[1]});
        apb(1'b1, `OFS_CTRL, 32'h00000500);
        settle(3);
        relay(2'b01);
        flt(1'b1);
        settle(22);
        relay(2'b10);
        flt(1'b0);
        settle(3);
        relay(2'b01);
        complete_run;
    end
endmodule
